/* design/smisp_slave_port.sv */
module smisp_slave_port #(
  parameter int AXI_ADDR_W = 8
) (
  // Clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // AXI4-Lite write address and data
  input  wire logic                  awvalid,
  output logic                       awready,
  input  wire logic [AXI_ADDR_W-1:0] awaddr,
  input  wire logic                  wvalid,
  output logic                       wready,
  input  wire logic [31:0]           wdata,
  input  wire logic [3:0]            wstrb,
  // AXI4-Lite write response
  output logic                       bvalid,
  input  wire logic                  bready,
  output logic [1:0]                 bresp,
  // AXI4-Lite read
  input  wire logic                  arvalid,
  output logic                       arready,
  input  wire logic [AXI_ADDR_W-1:0] araddr,
  output logic                       rvalid,
  input  wire logic                  rready,
  output logic [31:0]                rdata,
  output logic [1:0]                 rresp,
  // I2C pins, open drain
  input  wire logic                  scl_in,
  output logic                       scl_out,
  output logic                       scl_oe_n,
  input  wire logic                  sda_in,
  output logic                       sda_out,
  output logic                       sda_oe_n,
  // System side
  input  wire logic                  timeout_event,
  output logic                       i2c_irq,
  output logic                       wake_request,
  output logic                       spi_master_mode,
  output logic                       spi_slave_mode,
  output logic [2:0]                 spi_clk_sel
);

  if (AXI_ADDR_W < 5) begin : g_bad_width
    $error("AXI_ADDR_W must be at least 5");
  end

  function automatic smisp_pkg::smisp_sel_type reg_sel(input logic [AXI_ADDR_W-1:0] a);
    logic [4:0] w;
    w = {a[4:2], 2'b00};
    if ((a >> 5) != '0) reg_sel = smisp_pkg::SEL_NONE;
    else if (w == smisp_pkg::OFS_DATA) reg_sel = smisp_pkg::SEL_DATA;
    else if (w == smisp_pkg::OFS_ADDR) reg_sel = smisp_pkg::SEL_ADDR;
    else if (w == smisp_pkg::OFS_MODE) reg_sel = smisp_pkg::SEL_MODE;
    else if (w == smisp_pkg::OFS_STAT) reg_sel = smisp_pkg::SEL_STAT;
    else reg_sel = smisp_pkg::SEL_NONE;
  endfunction

  // Software state
  logic [2:0] mode_field;
  logic [1:0] debounce_select;
  logic       module_enable;
  logic       spi_incomplete_flag;
  logic [7:0] own_slave_address;
  logic       transmit_select;
  logic       ack_send_bit;
  logic       match_wakeup_enable;
  logic [7:0] serial_data_byte;
  logic       enable_q;
  // Engine state
  smisp_pkg::smisp_state_type st;
  logic [3:0] bit_cnt;
  logic [7:0] shift_in;
  logic [7:0] tx_shift;
  logic       transfer_complete_flag;
  logic       address_match_flag;
  logic       bus_busy_flag;
  logic       master_read_flag;
  logic       ack_received_flag;
  logic       drive_low;
  // Bus side
  logic [AXI_ADDR_W-1:0] aw_addr_q;
  logic [7:0]            w_data_q;
  logic                  w_lane0_q;
  logic                  wr_fire;
  logic                  wr_en;
  smisp_pkg::smisp_sel_type wr_sel;
  smisp_pkg::smisp_sel_type rd_sel;
  logic [7:0]            rd_byte;
  // Line conditioning
  logic [1:0] line_f;
  logic       scl_p;
  logic       sda_p;
  logic [2:0] deb_len;
  logic       active;
  logic       en_rise;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_cond;
  logic       stop_cond;
  logic       release_req;
  logic       rx_end;
  logic       addr_eq;

  assign wr_fire = !awready && !wready && !bvalid;
  assign wr_sel  = reg_sel(aw_addr_q);
  assign rd_sel  = reg_sel(araddr);
  assign wr_en   = wr_fire && w_lane0_q;
  assign active  = module_enable && (mode_field == smisp_pkg::MODE_I2C);
  assign en_rise = active && !enable_q;
  assign addr_eq = shift_in[7:1] == own_slave_address[7:1];

  always_comb begin
    if (debounce_select == 2'h0) deb_len = smisp_pkg::DEB_NONE;
    else if (debounce_select == 2'h1) deb_len = smisp_pkg::DEB_TWO;
    else deb_len = smisp_pkg::DEB_FOUR;
  end

  // Two-stage synchroniser then a stability filter per line; 0 is scl, 1 is sda
  for (genvar i = 0; i < 2; i++) begin : g_line
    logic       s1;
    logic       s2;
    logic       filt;
    logic [2:0] cnt;
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        s1   <= 1'b1;
        s2   <= 1'b1;
        filt <= 1'b1;
        cnt  <= 3'h0;
      end else begin
        s1 <= (i == 0) ? scl_in : sda_in;
        s2 <= s1;
        if (s2 == filt) begin
          cnt <= 3'h0;
        end else if (cnt >= deb_len || !active) begin
          filt <= s2;
          cnt  <= 3'h0;
        end else begin
          cnt <= cnt + 3'h1;
        end
      end
    end
    assign line_f[i] = filt;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scl_p <= 1'b1;
      sda_p <= 1'b1;
    end else begin
      scl_p <= line_f[0];
      sda_p <= line_f[1];
    end
  end

  assign scl_rise   = line_f[0] && !scl_p;
  assign scl_fall   = !line_f[0] && scl_p;
  assign start_cond = line_f[0] && scl_p && sda_p && !line_f[1];
  assign stop_cond  = line_f[0] && scl_p && !sda_p && line_f[1];
  assign release_req = (st == smisp_pkg::ST_HOLD) && (
      (wr_en && wr_sel == smisp_pkg::SEL_DATA && transmit_select) ||
      (arvalid && arready && rd_sel == smisp_pkg::SEL_DATA && !transmit_select));
  assign rx_end = active && !en_rise && !timeout_event && !start_cond && !stop_cond &&
                  st == smisp_pkg::ST_RX && scl_fall && bit_cnt == smisp_pkg::BITS_BYTE;

  // Write channels; address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready   <= 1'b1;
      wready    <= 1'b1;
      bvalid    <= 1'b0;
      bresp     <= smisp_pkg::RESP_OKAY;
      aw_addr_q <= '0;
      w_data_q  <= 8'h00;
      w_lane0_q <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        awready   <= 1'b0;
        aw_addr_q <= awaddr;
      end
      if (wvalid && wready) begin
        wready    <= 1'b0;
        w_data_q  <= wdata[7:0];
        w_lane0_q <= wstrb[0];
      end
      if (wr_fire) begin
        bvalid <= 1'b1;
        bresp  <= (wr_sel == smisp_pkg::SEL_NONE) ? smisp_pkg::RESP_SLVERR
                                                  : smisp_pkg::RESP_OKAY;
      end else if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  always_comb begin
    if (rd_sel == smisp_pkg::SEL_DATA) rd_byte = serial_data_byte;
    else if (rd_sel == smisp_pkg::SEL_ADDR) rd_byte = own_slave_address;
    else if (rd_sel == smisp_pkg::SEL_MODE) rd_byte = {mode_field, 1'b0, debounce_select,
                                                       module_enable, spi_incomplete_flag};
    else if (rd_sel == smisp_pkg::SEL_STAT) rd_byte = {transfer_complete_flag,
        address_match_flag, bus_busy_flag, transmit_select, ack_send_bit,
        master_read_flag, match_wakeup_enable, ack_received_flag};
    else rd_byte = 8'h00;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h00000000;
      rresp   <= smisp_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= {24'h000000, rd_byte};
      rresp   <= (rd_sel == smisp_pkg::SEL_NONE) ? smisp_pkg::RESP_SLVERR
                                                 : smisp_pkg::RESP_OKAY;
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

  // Control registers; none is touched by an enable rise
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_field          <= smisp_pkg::MODE_RST[smisp_pkg::MODE_LSB +: 3];
      debounce_select     <= smisp_pkg::MODE_RST[smisp_pkg::DEB_LSB +: 2];
      module_enable       <= smisp_pkg::MODE_RST[smisp_pkg::EN_BIT];
      spi_incomplete_flag <= smisp_pkg::MODE_RST[smisp_pkg::ICF_BIT];
      own_slave_address   <= smisp_pkg::ADDR_RST;
      transmit_select     <= smisp_pkg::STAT_RST[smisp_pkg::TX_BIT];
      ack_send_bit        <= smisp_pkg::STAT_RST[smisp_pkg::ACK_SEND_BIT_BIT];
      match_wakeup_enable <= smisp_pkg::STAT_RST[smisp_pkg::WU_BIT];
      enable_q            <= 1'b0;
    end else begin
      enable_q <= active;
      if (wr_en && wr_sel == smisp_pkg::SEL_ADDR) begin
        own_slave_address <= w_data_q;
      end
      if (wr_en && wr_sel == smisp_pkg::SEL_MODE) begin
        mode_field          <= w_data_q[smisp_pkg::MODE_LSB +: 3];
        debounce_select     <= w_data_q[smisp_pkg::DEB_LSB +: 2];
        module_enable       <= w_data_q[smisp_pkg::EN_BIT];
        spi_incomplete_flag <= w_data_q[smisp_pkg::ICF_BIT];
      end
      // Time-out returns the whole status register to its reset state
      if (active && timeout_event) begin
        transmit_select     <= smisp_pkg::STAT_RST[smisp_pkg::TX_BIT];
        ack_send_bit        <= smisp_pkg::STAT_RST[smisp_pkg::ACK_SEND_BIT_BIT];
        match_wakeup_enable <= smisp_pkg::STAT_RST[smisp_pkg::WU_BIT];
      end else if (wr_en && wr_sel == smisp_pkg::SEL_STAT) begin
        transmit_select     <= w_data_q[smisp_pkg::TX_BIT];
        ack_send_bit        <= w_data_q[smisp_pkg::ACK_SEND_BIT_BIT];
        match_wakeup_enable <= w_data_q[smisp_pkg::WU_BIT];
      end
    end
  end

  // Data register has no reset on purpose: its content is undefined until used
  always_ff @(posedge aclk) begin
    if (wr_en && wr_sel == smisp_pkg::SEL_DATA) begin
      serial_data_byte <= w_data_q;
    end else if (rx_end) begin
      serial_data_byte <= shift_in;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      spi_master_mode <= 1'b0;
      spi_slave_mode  <= 1'b0;
      spi_clk_sel     <= 3'h0;
      drive_low       <= 1'b0;
    end else begin
      spi_master_mode <= module_enable && mode_field <= smisp_pkg::MODE_SPI_M_LAST;
      spi_slave_mode  <= module_enable && mode_field == smisp_pkg::MODE_SPI_S;
      spi_clk_sel     <= (mode_field <= smisp_pkg::MODE_SPI_M_LAST) ? mode_field
                                                                    : 3'h0;
      drive_low       <= 1'b0;
    end
  end

  assign scl_out = drive_low;
  assign sda_out = drive_low;

  // I2C slave engine
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st                     <= smisp_pkg::ST_IDLE;
      bit_cnt                <= 4'h0;
      shift_in               <= 8'h00;
      tx_shift               <= 8'h00;
      transfer_complete_flag <= smisp_pkg::STAT_RST[smisp_pkg::CF_BIT];
      address_match_flag     <= smisp_pkg::STAT_RST[smisp_pkg::MATCH_BIT];
      bus_busy_flag          <= smisp_pkg::STAT_RST[smisp_pkg::BUSY_BIT];
      master_read_flag       <= smisp_pkg::STAT_RST[smisp_pkg::RW_BIT];
      ack_received_flag      <= smisp_pkg::STAT_RST[smisp_pkg::ACK_RECEIVED_FLAG_BIT];
      scl_oe_n               <= 1'b1;
      sda_oe_n               <= 1'b1;
      i2c_irq                <= 1'b0;
      wake_request           <= 1'b0;
    end else begin
      i2c_irq      <= 1'b0;
      wake_request <= 1'b0;
      if (!active) begin
        st       <= smisp_pkg::ST_IDLE;
        scl_oe_n <= 1'b1;
        sda_oe_n <= 1'b1;
      end else if (en_rise || timeout_event) begin
        st                     <= smisp_pkg::ST_IDLE;
        transfer_complete_flag <= smisp_pkg::STAT_RST[smisp_pkg::CF_BIT];
        address_match_flag     <= smisp_pkg::STAT_RST[smisp_pkg::MATCH_BIT];
        bus_busy_flag          <= smisp_pkg::STAT_RST[smisp_pkg::BUSY_BIT];
        master_read_flag       <= smisp_pkg::STAT_RST[smisp_pkg::RW_BIT];
        ack_received_flag      <= smisp_pkg::STAT_RST[smisp_pkg::ACK_RECEIVED_FLAG_BIT];
        scl_oe_n               <= 1'b1;
        sda_oe_n               <= 1'b1;
        i2c_irq                <= timeout_event;
      end else if (start_cond) begin
        bus_busy_flag          <= 1'b1;
        st                     <= smisp_pkg::ST_ADDR;
        bit_cnt                <= 4'h0;
        transfer_complete_flag <= 1'b0;
        address_match_flag     <= 1'b0;
        scl_oe_n               <= 1'b1;
        sda_oe_n               <= 1'b1;
      end else if (stop_cond) begin
        bus_busy_flag      <= 1'b0;
        address_match_flag <= 1'b0;
        st                 <= smisp_pkg::ST_IDLE;
        scl_oe_n           <= 1'b1;
        sda_oe_n           <= 1'b1;
      end else if (st == smisp_pkg::ST_HOLD) begin
        // Clock stays low until software writes the data register when transmitting or reads it when receiving
        if (release_req) begin
          scl_oe_n               <= 1'b1;
          bit_cnt                <= 4'h0;
          transfer_complete_flag <= 1'b0;
          if (transmit_select) begin
            st       <= smisp_pkg::ST_TX;
            tx_shift <= w_data_q;
            sda_oe_n <= w_data_q[7];
          end else begin
            st <= smisp_pkg::ST_RX;
          end
        end
      end else if (scl_rise) begin
        if (st == smisp_pkg::ST_ADDR || st == smisp_pkg::ST_RX) begin
          if (bit_cnt < smisp_pkg::BITS_BYTE) begin
            shift_in <= {shift_in[6:0], line_f[1]};
          end
          if (bit_cnt < smisp_pkg::BITS_ACK) bit_cnt <= bit_cnt + 4'h1;
        end else if (st == smisp_pkg::ST_TX) begin
          if (bit_cnt == smisp_pkg::BITS_BYTE) ack_received_flag <= line_f[1];
          if (bit_cnt < smisp_pkg::BITS_ACK) bit_cnt <= bit_cnt + 4'h1;
        end
      end else if (scl_fall) begin
        if (st == smisp_pkg::ST_ADDR && bit_cnt == smisp_pkg::BITS_BYTE) begin
          if (addr_eq) begin
            address_match_flag     <= 1'b1;
            master_read_flag       <= shift_in[0];
            transfer_complete_flag <= 1'b1;
            sda_oe_n               <= 1'b0;
            i2c_irq                <= 1'b1;
            wake_request           <= match_wakeup_enable;
          end else begin
            st <= smisp_pkg::ST_IDLE;
          end
        end else if (st == smisp_pkg::ST_RX && bit_cnt == smisp_pkg::BITS_BYTE) begin
          transfer_complete_flag <= 1'b1;
          sda_oe_n               <= ack_send_bit;
          i2c_irq                <= 1'b1;
        end else if (st == smisp_pkg::ST_TX && bit_cnt == smisp_pkg::BITS_BYTE) begin
          transfer_complete_flag <= 1'b1;
          sda_oe_n               <= 1'b1;
          i2c_irq                <= 1'b1;
        end else if (st == smisp_pkg::ST_TX && bit_cnt == smisp_pkg::BITS_ACK) begin
          // No acknowledge from the master: data line stays free for its STOP
          if (!ack_received_flag) begin
            scl_oe_n <= 1'b0;
            st       <= smisp_pkg::ST_HOLD;
          end else begin
            st <= smisp_pkg::ST_IDLE;
          end
        end else if (st == smisp_pkg::ST_TX && bit_cnt != 4'h0) begin
          tx_shift <= {tx_shift[6:0], 1'b0};
          sda_oe_n <= tx_shift[6];
        end else if (bit_cnt == smisp_pkg::BITS_ACK &&
                     (st == smisp_pkg::ST_ADDR || st == smisp_pkg::ST_RX)) begin
          sda_oe_n <= 1'b1;
          scl_oe_n <= 1'b0;
          st       <= smisp_pkg::ST_HOLD;
        end
      end
    end
  end

  chk_mode_reset: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(aresetn) |-> mode_field == smisp_pkg::MODE_OFF)
    else $error("mode field not off after reset");

  chk_bit4_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    arvalid && arready && rd_sel == smisp_pkg::SEL_MODE |=> !rdata[4])
    else $error("mode register bit 4 read as one");

  chk_disable_release: assert property (@(posedge aclk) disable iff (!aresetn)
    !module_enable |=> scl_oe_n && sda_oe_n)
    else $error("pins driven while disabled");

  chk_enable_defaults: assert property (@(posedge aclk) disable iff (!aresetn)
    en_rise |=> transfer_complete_flag && !address_match_flag && !bus_busy_flag &&
                !master_read_flag && ack_received_flag)
    else $error("flags not defaulted on enable");

  chk_busy_start: assert property (@(posedge aclk) disable iff (!aresetn)
    active && !en_rise && !timeout_event && start_cond |=> bus_busy_flag)
    else $error("busy not set on start");

  chk_busy_stop: assert property (@(posedge aclk) disable iff (!aresetn)
    active && !en_rise && !timeout_event && !start_cond && stop_cond |=> !bus_busy_flag)
    else $error("busy not cleared on stop");

  chk_match_compare: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(address_match_flag) |-> $past(addr_eq) && i2c_irq)
    else $error("match without equal address or interrupt");

  chk_match_ack: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(address_match_flag) |-> !sda_oe_n)
    else $error("no acknowledge driven on match");

  chk_ack_send_bit_drive: assert property (@(posedge aclk) disable iff (!aresetn)
    rx_end |=> sda_oe_n == $past(ack_send_bit) && transfer_complete_flag)
    else $error("ack-send bit not driven after byte");

  chk_hold_scl: assert property (@(posedge aclk) disable iff (!aresetn)
    st == smisp_pkg::ST_HOLD ##1 st == smisp_pkg::ST_HOLD |-> !scl_oe_n)
    else $error("clock not held low while waiting");

endmodule

/* shared/smisp_pkg.sv */
package smisp_pkg;

  // Register byte offsets on the AXI4-Lite slave
  localparam logic [4:0] OFS_DATA = 5'h00;
  localparam logic [4:0] OFS_ADDR = 5'h04;
  localparam logic [4:0] OFS_MODE = 5'h08;
  localparam logic [4:0] OFS_STAT = 5'h0C;

  // Operating mode codes
  localparam logic [2:0] MODE_SPI_M_LAST = 3'h4;
  localparam logic [2:0] MODE_SPI_S      = 3'h5;
  localparam logic [2:0] MODE_I2C        = 3'h6;
  localparam logic [2:0] MODE_OFF        = 3'h7;

  // Debounce lengths in system clocks
  localparam logic [2:0] DEB_NONE = 3'h0;
  localparam logic [2:0] DEB_TWO  = 3'h2;
  localparam logic [2:0] DEB_FOUR = 3'h4;

  // Field positions of mode_enable_control
  localparam int MODE_LSB = 5;
  localparam int DEB_LSB  = 2;
  localparam int EN_BIT   = 1;
  localparam int ICF_BIT  = 0;

  // Field positions of bus_status_control
  localparam int CF_BIT   = 7;
  localparam int MATCH_BIT = 6;
  localparam int BUSY_BIT = 5;
  localparam int TX_BIT   = 4;
  localparam int ACK_SEND_BIT_BIT = 3;
  localparam int RW_BIT   = 2;
  localparam int WU_BIT   = 1;
  localparam int ACK_RECEIVED_FLAG_BIT = 0;

  // Values after reset
  localparam logic [7:0] MODE_RST = 8'hE0;
  localparam logic [7:0] STAT_RST = 8'h81;
  localparam logic [7:0] ADDR_RST = 8'h00;

  // Bit counts of a byte and of a byte plus acknowledge
  localparam logic [3:0] BITS_BYTE = 4'h8;
  localparam logic [3:0] BITS_ACK  = 4'h9;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_RX, ST_TX, ST_HOLD} smisp_state_type;
  typedef enum logic [2:0] {SEL_NONE, SEL_DATA, SEL_ADDR, SEL_MODE, SEL_STAT} smisp_sel_type;

endpackage

/* testbench/serial_module_i2c_slave_port_bench.sv */
module serial_module_i2c_slave_port_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid;
  logic        arready, rvalid, rready, scl_out, scl_oe_n, sda_out, sda_oe_n, tmo;
  logic        m_scl, m_sda, scl_w, sda_w;
  logic [7:0]  awaddr, araddr, d;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, e;
  logic [8:0]  r;
  logic        irq, wake, spim, spis;
  logic [2:0]  csel;
  int          irq_n, wake_n;
  int          err_count, tests_run, cycles;
  assign scl_w = (scl_oe_n | scl_out) & m_scl;
  assign sda_w = (sda_oe_n | sda_out) & m_sda;
  always #2.5 aclk = ~aclk;
  smisp_slave_port smisp_slave_port_i (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp), .scl_in(scl_w), .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .timeout_event(tmo), .i2c_irq(irq),
    .wake_request(wake), .spi_master_mode(spim), .spi_slave_mode(spis), .spi_clk_sel(csel));
  smisp_i2c_master smisp_i2c_master_i (.clk(aclk), .scl_w(scl_w), .sda_w(sda_w),
    .m_scl(m_scl), .m_sda(m_sda));
  task automatic conclude();
    if (err_count == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [8:0] g, input logic [8:0] x);
    tests_run++;
    if (g !== x) begin
      err_count++;
      $display("BAD %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    awaddr <= a;
    wdata <= {24'h000000, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (awvalid || wvalid);
    do @(posedge aclk); while (!bvalid);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'b0;
    d = rdata[7:0];
    e = rresp;
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] x);
    rd(a);
    chk("register", 9'(d), 9'(x));
  endtask
  always @(posedge aclk) begin
    cycles++;
    if (irq === 1'b1) irq_n++;
    if (wake === 1'b1) wake_n++;
    if (cycles == 30000) begin
      err_count++;
      conclude();
    end
  end
  initial begin
    {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, tmo} = 8'h00;
    {awaddr, araddr, wdata, wstrb} = 52'h0000000000000F;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rc(8'h08, 8'hE0);
    rc(8'h0C, 8'h81);
    rc(8'h04, 8'h00);
    wr(8'h08, 8'hDA);
    rc(8'h08, 8'hCA);
    wr(8'h04, 8'hA5);
    rc(8'h04, 8'hA5);
    rd(8'h10);
    chk("rresp", 9'(e), 9'(smisp_pkg::RESP_SLVERR));
    smisp_i2c_master_i.start();
    smisp_i2c_master_i.xfer(9'h0A9, r);
    chk("ack", 9'(r[0]), 9'h001);
    smisp_i2c_master_i.stop();
    rc(8'h0C, 8'h01);
    chk("irq", 9'(irq_n), 9'h000);
    smisp_i2c_master_i.start();
    smisp_i2c_master_i.xfer(9'h149, r);
    chk("ack", 9'(r[0]), 9'h000);
    rc(8'h0C, 8'hE1);
    rd(8'h00);
    smisp_i2c_master_i.xfer(9'h079, r);
    chk("ack", 9'(r[0]), 9'h000);
    rc(8'h00, 8'h3C);
    wr(8'h0C, 8'h08);
    smisp_i2c_master_i.xfer(9'h1E1, r);
    chk("ack", 9'(r[0]), 9'h001);
    rc(8'h00, 8'hF0);
    smisp_i2c_master_i.stop();
    rc(8'h0C, 8'h09);
    wr(8'h0C, 8'h0A);
    smisp_i2c_master_i.start();
    smisp_i2c_master_i.xfer(9'h14B, r);
    chk("ack", 9'(r[0]), 9'h000);
    rc(8'h0C, 8'hEF);
    wr(8'h0C, 8'h18);
    wr(8'h00, 8'h96);
    smisp_i2c_master_i.xfer(9'h1FF, r);
    chk("tx byte", 9'(r[8:1]), 9'h096);
    rc(8'h0C, 8'hFD);
    smisp_i2c_master_i.stop();
    tmo <= 1'b1;
    @(posedge aclk);
    tmo <= 1'b0;
    rc(8'h0C, 8'h81);
    chk("irq", 9'(irq_n), 9'h006);
    chk("wake", 9'(wake_n), 9'h001);
    wr(8'h08, 8'h22);
    repeat (2) @(posedge aclk);
    chk("spi", 9'({spim, spis, csel}), 9'h011);
    wr(8'h08, 8'hA2);
    repeat (2) @(posedge aclk);
    chk("spi", 9'({spim, spis, csel}), 9'h008);
    conclude();
  end
endmodule

/* testbench/smisp_i2c_master.sv */
module smisp_i2c_master (
  // Clock and wire levels
  input  wire logic clk,
  input  wire logic scl_w,
  input  wire logic sda_w,
  // Master pull-downs, 1 = released
  output logic      m_scl,
  output logic      m_sda
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    m_scl = 1'b1;
    m_sda = 1'b1;
  end
  task automatic gap();
    repeat (20) @(posedge clk);
  endtask
  task automatic start();
    m_sda <= 1'b0;
    gap();
    m_scl <= 1'b0;
    gap();
  endtask
  task automatic stop();
    m_sda <= 1'b0;
    gap();
    m_scl <= 1'b1;
    gap();
    m_sda <= 1'b1;
    gap();
  endtask
  // Nine bits; waits out any clock stretching by the slave
  task automatic xfer(input logic [8:0] b, output logic [8:0] r);
    for (int i = 8; i >= 0; i--) begin
      m_sda <= b[i];
      gap();
      m_scl <= 1'b1;
      wait (scl_w);
      gap();
      r[i] = sda_w;
      m_scl <= 1'b0;
      gap();
    end
    m_sda <= 1'b0;
  endtask
endmodule
